// ==== asb_peer.sv ====
/*
  Far-side serial peripheral model: clocks the link and echoes each bit inverted.
  Assumes the bench raises run only for the span of one transfer.
*/
`timescale 1ns/100ps
`default_nettype none

module asb_peer (
  input  wire logic run,
  input  wire logic serial_out_pin,
  output var  logic serial_clock_pin,
  output var  logic serial_in_pin
);
  // The echo follows the data line at once, so each bit comes back inverted
  // 5 ns before the rising edge on which the block samples it.
  assign serial_in_pin = ~serial_out_pin;

  initial begin
    serial_clock_pin = 1'b1;
  end

  // fall drives, rise samples
  // The clock stands high outside a transfer; its edges sit 5 ns after mclk edges.
  always begin
    wait (run);
    #5;
    while (run) begin
      serial_clock_pin = 1'b0;
      #80;
      serial_clock_pin = 1'b1;
      #80;
    end
  end
endmodule // asb_peer

`default_nettype wire

// ==== asb_pkg.sv ====
/*
  Shared constants for the automatic serial buffer transfer block: register
  indices, field positions, reset values, gap timing counts and engine states.
  Assumes a register bus whose byte address is four times a register index.
*/
`default_nettype none

package asb_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [15:0] IDX_MODE     = 16'hFF68;
  localparam logic [15:0] IDX_CTRL     = 16'hFF69;
  localparam logic [15:0] IDX_PTR      = 16'hFF6A;
  localparam logic [15:0] IDX_GAP      = 16'hFF6B;
  localparam logic [15:0] IDX_SHIFT    = 16'hFF6C;
  localparam logic [15:0] IDX_STATUS   = 16'hFF6D;
  localparam logic [15:0] IDX_PORT     = 16'hFF6E;
  localparam logic [15:0] IDX_RAM_LO   = 16'hFAC0;
  localparam logic [15:0] IDX_RAM_HI   = 16'hFAFF;
  localparam int unsigned ADDR_W       = 18;
  localparam int unsigned RAM_DEPTH    = 64;

  // Field positions.
  localparam int unsigned MODE_ON      = 7;
  localparam int unsigned MODE_AUTO    = 5;
  localparam int unsigned CTRL_RX_ON   = 7;
  localparam int unsigned CTRL_RELOAD  = 6;
  localparam int unsigned CTRL_SLIP    = 4;
  localparam int unsigned CTRL_ACTIVE  = 3;
  localparam int unsigned CTRL_STROBE  = 2;
  localparam int unsigned CTRL_HOLD    = 1;
  localparam int unsigned GAP_ON       = 7;
  localparam int unsigned STAT_IRQ     = 0;
  localparam int unsigned PORT_STROBE  = 0;
  localparam int unsigned PORT_BUSY    = 1;

  // Reset values.
  localparam logic [7:0]  RST_BYTE     = 8'h00;

  // Gap timing in main clock cycles, and the minimum count of serial clock rises.
  localparam int unsigned GAP_UNIT_CYC = 128;
  localparam int unsigned GAP_MIN_CYC  = 56;
  localparam int unsigned GAP_MAX_CYC  = 72;
  localparam logic [12:0] GAP_RAM_CYC  = 13'h0002;
  localparam logic [1:0]  GAP_SCK_MIN  = 2'h2;

  // Bus responses.
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LOAD,
    ST_SHIFT,
    ST_STORE,
    ST_GAP
  } asb_state_t;

  function automatic logic asb_is_ram(input logic [15:0] idx);
    return (idx >= IDX_RAM_LO) && (idx <= IDX_RAM_HI);
  endfunction

endpackage

`default_nettype wire

// ==== asb_shifter.sv ====
/*
  Eight-bit serial shift register for the three-wire channel.
  Assumes serial clock edges arrive as one-cycle pulses already synchronised
  to mclk, and that the serial input is synchronised as well.
*/
`timescale 1ns/100ps
`default_nettype none

module asb_shifter (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       sck_rise,
  input  wire logic       sck_fall,
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  input  wire logic       clr,
  input  wire logic       sin,
  output var  logic       sout,
  output var  logic       done,
  output var  logic [7:0] rx_data
);

  logic [7:0] sr;
  logic [7:0] next_sr;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic       busy;
  logic       next_busy;
  logic       next_sout;
  logic       next_done;

  always_comb begin
    next_sr   = sr;
    next_cnt  = cnt;
    next_busy = busy;
    next_sout = sout;
    next_done = 1'b0;
    if (clr) begin
      next_busy = 1'b0;
      next_sout = 1'b0;
    end else if (load) begin
      next_sr   = load_data;
      next_sout = load_data[7];
      next_cnt  = 3'h0;
      next_busy = 1'b1;
    end else if (busy) begin
      if (sck_rise) begin
        next_sr  = {sr[6:0], sin};
        next_cnt = 3'(cnt + 3'h1);
        if (cnt == 3'h7) begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end
      end else if (sck_fall) begin
        next_sout = sr[7];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sr   <= 8'h00;
      cnt  <= 3'h0;
      busy <= 1'b0;
      sout <= 1'b0;
      done <= 1'b0;
    end else begin
      sr   <= next_sr;
      cnt  <= next_cnt;
      busy <= next_busy;
      sout <= next_sout;
      done <= next_done;
    end
  end

  assign rx_data = sr;

endmodule // asb_shifter

`default_nettype wire

// ==== asb_top.sv ====
/*
  Automatic serial buffer transfer engine with an AXI4-Lite register slave,
  a 64-byte buffer RAM and a gap timer between bytes.
  Assumes the serial clock, serial input and busy input come from outside
  the mclk domain and that the serial clock runs well below mclk.
*/
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none

module asb_top #(
  parameter int unsigned GAP_UNIT = asb_pkg::GAP_UNIT_CYC
) (
  input  wire logic                       mclk,
  input  wire logic                       rst,
  input  wire logic [asb_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output var  logic                       awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output var  logic                       wready,
  output var  logic [1:0]                 bresp,
  output var  logic                       bvalid,
  input  wire logic                       bready,
  input  wire logic [asb_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output var  logic                       arready,
  output var  logic [31:0]                rdata,
  output var  logic [1:0]                 rresp,
  output var  logic                       rvalid,
  input  wire logic                       rready,
  input  wire logic                       serial_clock_pin,
  input  wire logic                       serial_in_pin,
  output var  logic                       serial_out_pin,
  input  wire logic                       busy_pin,
  output var  logic                       strobe_pin
);

  logic                sck_s1, sck_s2, sck_s3, sin_s1, sin_s2, busy_s1, busy_s2;
  logic                sck_rise, sck_fall;
  logic [7:0]          buf_ram [asb_pkg::RAM_DEPTH];
  asb_pkg::asb_state_t st, next_st;
  logic [7:0]          mode, next_mode, ptr, next_ptr, sio_rx, next_sio_rx;
  logic [4:0]          gap_n, next_gap_n;
  logic                gap_on, next_gap_on, rx_on, next_rx_on, reload, next_reload;
  logic                strobe_ctrl, next_strobe_ctrl, hold_ctrl, next_hold_ctrl;
  logic                active, next_active, irq_flag, next_irq_flag;
  logic                next_strobe_pin;
  logic [12:0]         gap_cnt, next_gap_cnt;
  logic [1:0]          rises, next_rises;
  logic [15:0]         aw_idx, next_aw_idx;
  logic [7:0]          wd, next_wd;
  logic                wd_en, next_wd_en, have_aw, next_have_aw, have_w, next_have_w;
  logic                next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]          next_bresp, next_rresp;
  logic [31:0]         next_rdata;
  logic [15:0]         ar_idx;
  logic [7:0]          rd8;
  logic                wr_go, sio_wr, irq_set;
  logic                ram_we;
  logic [5:0]          ram_wa;
  logic [7:0]          ram_wd;
  logic                sh_load, sh_clr, sh_done, sh_out;
  logic [7:0]          sh_data, sh_rx;

  // Two-stage synchronisers; the second stage feeds logic, and sck_s3 behind it gives the serial clock edge detect.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sck_s1  <= 1'b1;
      sck_s2  <= 1'b1;
      sck_s3  <= 1'b1;
      sin_s1  <= 1'b0;
      sin_s2  <= 1'b0;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
    end else begin
      sck_s1  <= serial_clock_pin;
      sck_s2  <= sck_s1;
      sck_s3  <= sck_s2;
      sin_s1  <= serial_in_pin;
      sin_s2  <= sin_s1;
      busy_s1 <= busy_pin;
      busy_s2 <= busy_s1;
    end
  end

  assign sck_rise = sck_s2 & ~sck_s3;
  assign sck_fall = ~sck_s2 & sck_s3;
  assign ar_idx   = araddr[asb_pkg::ADDR_W-1:2];

  always_ff @(posedge mclk) begin
    if (ram_we) begin
      buf_ram[ram_wa] <= ram_wd;
    end
  end

  asb_shifter u_shifter (
    .mclk      (mclk),
    .rst       (rst),
    .sck_rise  (sck_rise),
    .sck_fall  (sck_fall),
    .load      (sh_load),
    .load_data (sh_data),
    .clr       (sh_clr),
    .sin       (sin_s2),
    .sout      (sh_out),
    .done      (sh_done),
    .rx_data   (sh_rx)
  );

  always_comb begin
    next_st = st;  next_mode = mode;  next_ptr = ptr;  next_sio_rx = sio_rx;
    next_gap_n = gap_n;  next_gap_on = gap_on;  next_rx_on = rx_on;
    next_reload = reload;  next_strobe_ctrl = strobe_ctrl;  next_hold_ctrl = hold_ctrl;
    next_active = active;  next_irq_flag = irq_flag;  next_strobe_pin = strobe_pin;
    next_gap_cnt = gap_cnt;  next_rises = rises;
    next_aw_idx = aw_idx;  next_wd = wd;  next_wd_en = wd_en;
    next_have_aw = have_aw;  next_have_w = have_w;
    next_awready = awready;  next_wready = wready;  next_bvalid = bvalid;
    next_bresp = bresp;  next_arready = arready;  next_rvalid = rvalid;
    next_rresp = rresp;  next_rdata = rdata;
    sio_wr = 1'b0;  irq_set = 1'b0;
    ram_we = 1'b0;  ram_wa = ptr[5:0];  ram_wd = sh_rx;
    sh_load = 1'b0;  sh_clr = 1'b0;  sh_data = buf_ram[ptr[5:0]];
    rd8 = 8'h00;

    if (awvalid && awready) begin
      next_aw_idx  = awaddr[asb_pkg::ADDR_W-1:2];
      next_have_aw = 1'b1;
      next_awready = 1'b0;
    end
    if (wvalid && wready) begin
      next_wd     = wdata[7:0];
      next_wd_en  = wstrb[0];
      next_have_w = 1'b1;
      next_wready = 1'b0;
    end
    // A buffer write from the bus waits while the engine stores a byte.
    wr_go = have_aw && have_w && !bvalid &&
            !(asb_pkg::asb_is_ram(aw_idx) && st == asb_pkg::ST_STORE);
    if (wr_go) begin
      next_have_aw = 1'b0;
      next_have_w  = 1'b0;
      next_awready = 1'b1;
      next_wready  = 1'b1;
      next_bvalid  = 1'b1;
      next_bresp   = asb_pkg::RESP_OKAY;
      if (asb_pkg::asb_is_ram(aw_idx)) begin
        ram_we = wd_en;
        ram_wa = aw_idx[5:0];
        ram_wd = wd;
      end else if (aw_idx == asb_pkg::IDX_MODE) begin
        if (wd_en) next_mode = wd;
      end else if (aw_idx == asb_pkg::IDX_CTRL) begin
        if (wd_en) begin
          next_rx_on       = wd[asb_pkg::CTRL_RX_ON];
          next_reload      = wd[asb_pkg::CTRL_RELOAD];
          next_strobe_ctrl = wd[asb_pkg::CTRL_STROBE];
          next_hold_ctrl   = wd[asb_pkg::CTRL_HOLD];
        end
      end else if (aw_idx == asb_pkg::IDX_GAP) begin
        if (wd_en) begin
          next_gap_on = wd[asb_pkg::GAP_ON];
          next_gap_n  = wd[4:0];
        end
      end else if (aw_idx == asb_pkg::IDX_PTR) begin
        if (wd_en) next_ptr = wd;
      end else if (aw_idx == asb_pkg::IDX_SHIFT) begin
        sio_wr = 1'b1;
      end else if (aw_idx == asb_pkg::IDX_STATUS) begin
        if (wd_en && wd[asb_pkg::STAT_IRQ]) next_irq_flag = 1'b0;
      end else if (aw_idx == asb_pkg::IDX_PORT) begin
        if (wd_en) next_strobe_pin = wd[asb_pkg::PORT_STROBE];
      end else begin
        next_bresp = asb_pkg::RESP_SLVERR;
      end
    end
    if (bvalid && bready) next_bvalid = 1'b0;

    if (arvalid && arready) begin
      next_arready = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = asb_pkg::RESP_OKAY;
      if (asb_pkg::asb_is_ram(ar_idx)) begin
        rd8 = buf_ram[ar_idx[5:0]];
      end else if (ar_idx == asb_pkg::IDX_MODE) begin
        rd8 = mode;
      end else if (ar_idx == asb_pkg::IDX_CTRL) begin
        rd8[asb_pkg::CTRL_RX_ON]  = rx_on;
        rd8[asb_pkg::CTRL_RELOAD] = reload;
        rd8[asb_pkg::CTRL_ACTIVE] = active;
        rd8[asb_pkg::CTRL_STROBE] = strobe_ctrl;
        rd8[asb_pkg::CTRL_HOLD]   = hold_ctrl;
      end else if (ar_idx == asb_pkg::IDX_GAP) begin
        rd8[asb_pkg::GAP_ON] = gap_on;
        rd8[4:0]             = gap_n;
      end else if (ar_idx == asb_pkg::IDX_PTR) begin
        rd8 = ptr;
      end else if (ar_idx == asb_pkg::IDX_SHIFT) begin
        rd8 = sio_rx;
      end else if (ar_idx == asb_pkg::IDX_STATUS) begin
        rd8[asb_pkg::STAT_IRQ] = irq_flag;
      end else if (ar_idx == asb_pkg::IDX_PORT) begin
        rd8[asb_pkg::PORT_STROBE] = strobe_pin;
        rd8[asb_pkg::PORT_BUSY]   = busy_s2;
      end else begin
        next_rresp = asb_pkg::RESP_SLVERR;
      end
      next_rdata = {24'h000000, rd8};
    end
    if (rvalid && rready) begin
      next_rvalid  = 1'b0;
      next_arready = 1'b1;
    end

    unique case (st)
      asb_pkg::ST_IDLE: begin
        if (sio_wr && mode[asb_pkg::MODE_ON]) begin
          if (mode[asb_pkg::MODE_AUTO]) begin
            next_active = 1'b1;
            next_st     = asb_pkg::ST_LOAD;
          end else begin
            sh_load = 1'b1;
            sh_data = wd;
            next_st = asb_pkg::ST_SHIFT;
          end
        end
      end
      asb_pkg::ST_LOAD: begin
        sh_load = 1'b1;
        sh_data = buf_ram[ptr[5:0]];
        next_st = asb_pkg::ST_SHIFT;
      end
      asb_pkg::ST_SHIFT: begin
        if (sh_done) begin
          next_sio_rx = sh_rx;
          if (active) begin
            next_st = asb_pkg::ST_STORE;
          end else begin
            irq_set = 1'b1;
            next_st = asb_pkg::ST_IDLE;
          end
        end
      end
      asb_pkg::ST_STORE: begin
        ram_we = rx_on;
        if (ptr == 8'h00) begin
          next_active = 1'b0;
          irq_set     = 1'b1;
          sh_clr      = 1'b1;
          next_st     = asb_pkg::ST_IDLE;
        end else begin
          next_ptr   = 8'(ptr - 8'h01);
          next_rises = 2'h0;
          next_gap_cnt = gap_on ?
            13'((32'(gap_n) + 32'd1) * GAP_UNIT + asb_pkg::GAP_MIN_CYC) :
            asb_pkg::GAP_RAM_CYC;
          next_st = asb_pkg::ST_GAP;
        end
      end
      asb_pkg::ST_GAP: begin
        if (gap_cnt != 13'h0000) next_gap_cnt = 13'(gap_cnt - 13'h0001);
        if (sck_rise && rises != asb_pkg::GAP_SCK_MIN) next_rises = 2'(rises + 2'h1);
        if (gap_cnt == 13'h0000 && rises == asb_pkg::GAP_SCK_MIN && sck_rise &&
            !(hold_ctrl && !gap_on && busy_s2)) begin
          next_st = asb_pkg::ST_LOAD;
        end
      end
    endcase
    // Hardware set wins over a software clear in the same cycle.
    if (irq_set) next_irq_flag = 1'b1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= asb_pkg::ST_IDLE;  mode <= asb_pkg::RST_BYTE;  ptr <= asb_pkg::RST_BYTE;
      sio_rx <= asb_pkg::RST_BYTE;  gap_n <= 5'h00;  gap_on <= 1'b0;  rx_on <= 1'b0;
      reload <= 1'b0;  strobe_ctrl <= 1'b0;  hold_ctrl <= 1'b0;  active <= 1'b0;
      irq_flag <= 1'b0;  strobe_pin <= 1'b0;  gap_cnt <= 13'h0000;  rises <= 2'h0;
      aw_idx <= 16'h0000;  wd <= 8'h00;  wd_en <= 1'b0;  have_aw <= 1'b0;
      have_w <= 1'b0;  awready <= 1'b1;  wready <= 1'b1;  bvalid <= 1'b0;
      bresp <= asb_pkg::RESP_OKAY;  arready <= 1'b1;  rvalid <= 1'b0;
      rresp <= asb_pkg::RESP_OKAY;  rdata <= 32'h00000000;  serial_out_pin <= 1'b0;
    end else begin
      st <= next_st;  mode <= next_mode;  ptr <= next_ptr;  sio_rx <= next_sio_rx;
      gap_n <= next_gap_n;  gap_on <= next_gap_on;  rx_on <= next_rx_on;
      reload <= next_reload;  strobe_ctrl <= next_strobe_ctrl;
      hold_ctrl <= next_hold_ctrl;  active <= next_active;  irq_flag <= next_irq_flag;
      strobe_pin <= next_strobe_pin;  gap_cnt <= next_gap_cnt;  rises <= next_rises;
      aw_idx <= next_aw_idx;  wd <= next_wd;  wd_en <= next_wd_en;
      have_aw <= next_have_aw;  have_w <= next_have_w;  awready <= next_awready;
      wready <= next_wready;  bvalid <= next_bvalid;  bresp <= next_bresp;
      arready <= next_arready;  rvalid <= next_rvalid;  rresp <= next_rresp;
      rdata <= next_rdata;  serial_out_pin <= sh_clr ? 1'b0 : sh_out;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  logic last_byte;
  assign last_byte = (st == asb_pkg::ST_STORE) && (ptr == 8'h00);

  auto_start_a: assert property (st == asb_pkg::ST_IDLE && sio_wr && mode[asb_pkg::MODE_ON] && mode[asb_pkg::MODE_AUTO] |=> active && st == asb_pkg::ST_LOAD ##1 st == asb_pkg::ST_SHIFT) else $error("auto start did not raise active and load");
  basic_gate_a: assert property (st == asb_pkg::ST_IDLE && sio_wr && !mode[asb_pkg::MODE_ON] |=> st == asb_pkg::ST_IDLE) else $error("transfer started with channel off");
  end_clear_a: assert property (last_byte |=> !active && st == asb_pkg::ST_IDLE) else $error("active not cleared at end");
  end_irq_a: assert property (last_byte |=> irq_flag) else $error("irq flag not set after last byte");
  out_low_a: assert property ($fell(active) |-> !serial_out_pin) else $error("serial out not low after end");
  ptr_step_a: assert property (st == asb_pkg::ST_STORE && ptr != 8'h00 |=> ptr == 8'($past(ptr) - 8'h01) && st == asb_pkg::ST_GAP) else $error("pointer not decremented");
  rx_store_a: assert property (st == asb_pkg::ST_STORE && rx_on |=> buf_ram[6'($past(ptr))] == $past(sh_rx)) else $error("received byte not stored");
  gap_load_a: assert property ($rose(st == asb_pkg::ST_GAP) && gap_on |-> gap_cnt == 13'((32'(gap_n) + 32'd1) * GAP_UNIT + asb_pkg::GAP_MIN_CYC)) else $error("gap count wrong");
  gap_sck_a: assert property (st == asb_pkg::ST_GAP ##1 st == asb_pkg::ST_LOAD |-> $past(rises) == asb_pkg::GAP_SCK_MIN) else $error("gap shorter than two serial clocks");
  busy_ignore_a: assert property (st == asb_pkg::ST_GAP && gap_on && gap_cnt == 13'h0000 && rises == asb_pkg::GAP_SCK_MIN && sck_rise |=> st == asb_pkg::ST_LOAD) else $error("busy held a counted gap");

endmodule // asb_top

`default_nettype wire

// ==== tb_asb_top.sv ====
/*
  Self-checking bench for the automatic serial buffer transfer block.
  Assumes the peer model returns the inverse of every bit it receives.
*/
`timescale 1ns/100ps
`default_nettype none

module tb_asb_top;
  localparam int unsigned UNIT = 4;
  logic                       mclk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic                       awready, wready, bvalid, arready, rvalid;
  logic                       run, busy_pin, sck, sin, sout, strobe;
  logic [asb_pkg::ADDR_W-1:0] awaddr, araddr;
  logic [31:0]                wdata, rdata;
  logic [3:0]                 wstrb;
  logic [1:0]                 bresp, rresp;
  int                         failures, compares, cyc, e_off, e_0, e_31;

  asb_top #(.GAP_UNIT(UNIT)) uut (.mclk(mclk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .serial_clock_pin(sck), .serial_in_pin(sin), .serial_out_pin(sout),
    .busy_pin(busy_pin), .strobe_pin(strobe));
  asb_peer peer (.run(run), .serial_out_pin(sout), .serial_clock_pin(sck), .serial_in_pin(sin));

  always #10 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 29 + 53);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_rng(input int v, input int lo, input int hi);
    compares++;
    if (v < lo || v > hi) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, v, lo, hi);
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    r = bresp;
    bready <= 1'b0;
    if (n >= 100) failures++;
  endtask

  task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    if (n >= 100) failures++;
  endtask

  task automatic wr_ok(input logic [15:0] idx, input logic [7:0] d);
    logic [1:0] r;
    wr(idx, d, r);
    chk({30'h0, r}, {30'h0, asb_pkg::RESP_OKAY});
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, asb_pkg::RESP_OKAY});
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    rd_chk(asb_pkg::IDX_GAP, 32'h0);
    rd_chk(asb_pkg::IDX_CTRL, 32'h0);
    wr_ok(asb_pkg::IDX_GAP, 8'h9F);
    rd_chk(asb_pkg::IDX_GAP, 32'h9F);
    wr_ok(asb_pkg::IDX_CTRL, 8'h18);
    rd_chk(asb_pkg::IDX_CTRL, 32'h0);
    wr(16'h0100, 8'h55, r);
    chk({30'h0, r}, {30'h0, asb_pkg::RESP_SLVERR});
    rd(16'h0100, d, r);
    chk({d[29:0], r}, {30'h0, asb_pkg::RESP_SLVERR});
    busy_pin <= 1'b1;
    wr_ok(asb_pkg::IDX_PORT, 8'h01);
    rd_chk(asb_pkg::IDX_PORT, 32'h3);
    chk({31'h0, strobe}, 32'h1);
    busy_pin <= 1'b0;
    $display("test regs done");
  endtask

  task automatic t_off;
    wr_ok(asb_pkg::IDX_MODE, 8'h00);
    wr_ok(asb_pkg::IDX_SHIFT, 8'h5A);
    repeat (20) @(posedge mclk);
    rd_chk(asb_pkg::IDX_CTRL, 32'h0);
    rd_chk(asb_pkg::IDX_STATUS, 32'h0);
    $display("test channel off done");
  endtask

  task automatic t_basic;
    logic [31:0] d;
    logic [1:0]  r;
    int          k;
    wr_ok(asb_pkg::IDX_MODE, 8'h80);
    wr_ok(asb_pkg::IDX_SHIFT, 8'h3C);
    run <= 1'b1;
    k = 0;
    do begin
      rd(asb_pkg::IDX_STATUS, d, r);
      k++;
    end while (d[0] !== 1'b1 && k < 200);
    run <= 1'b0;
    chk(d, 32'h1);
    rd_chk(asb_pkg::IDX_SHIFT, 32'hC3);
    rd_chk(asb_pkg::IDX_CTRL, 32'h0);
    wr_ok(asb_pkg::IDX_STATUS, 8'h01);
    rd_chk(asb_pkg::IDX_STATUS, 32'h0);
    $display("test basic done");
  endtask

  task automatic t_auto(input int nb, input logic [7:0] gap, output int el);
    logic [31:0] d;
    logic [1:0] r;
    int t0, k;
    for (int i = 0; i < 64; i++) wr_ok(asb_pkg::IDX_RAM_LO + 16'(i), pat(i));
    wr_ok(asb_pkg::IDX_GAP, gap);
    wr_ok(asb_pkg::IDX_PTR, 8'(nb - 1));
    wr_ok(asb_pkg::IDX_CTRL, 8'h80);
    wr_ok(asb_pkg::IDX_MODE, 8'hA0);
    wr_ok(asb_pkg::IDX_SHIFT, 8'hC3);
    t0 = cyc;
    rd_chk(asb_pkg::IDX_CTRL, 32'h88);
    run <= 1'b1;
    k = 0;
    do begin
      rd(asb_pkg::IDX_CTRL, d, r);
      k++;
    end while (d[3] !== 1'b0 && k < 3000);
    el = cyc - t0;
    run <= 1'b0;
    chk(d, 32'h80);
    chk({31'h0, sout}, 32'h0);
    rd_chk(asb_pkg::IDX_PTR, 32'h0);
    rd_chk(asb_pkg::IDX_STATUS, 32'h1);
    rd_chk(asb_pkg::IDX_SHIFT, {24'h0, ~pat(0)});
    for (int i = 0; i < 64; i++) begin
      rd_chk(asb_pkg::IDX_RAM_LO + 16'(i), {24'h0, i < nb ? ~pat(i) : pat(i)});
    end
    wr_ok(asb_pkg::IDX_STATUS, 8'h01);
    rd_chk(asb_pkg::IDX_STATUS, 32'h0);
    $display("test auto %0d bytes gap %h done", nb, gap);
  endtask

  task automatic test_done;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // The whole run takes some 8500 cycles; the limit of 50000 leaves margin.
  initial begin
    #1000000;
    failures++;
    test_done;
  end

  initial begin
    {mclk, awvalid, wvalid, bready, arvalid, rready, run, busy_pin} = 8'h00;
    {awaddr, araddr, wdata} = '0;
    {failures, compares, cyc} = '0;
    wstrb = 4'hF;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    t_regs;
    t_off;
    t_basic;
    t_auto(64, 8'h00, e_off);
    t_auto(2, 8'h00, e_off);
    t_auto(2, 8'h80, e_0);
    t_auto(2, 8'h9F, e_31);
    chk_rng(e_off, 2 * 64 + 16, e_0 - 1);
    chk_rng(e_0, 2 * 64 + UNIT + 56, 2 * 64 + UNIT + 72 + 50);
    chk_rng(e_31 - e_0, 31 * UNIT - 24, 31 * UNIT + 24);
    test_done;
  end
endmodule // tb_asb_top

`default_nettype wire
